/* core/wkt_regs.svh */
`ifndef WKT_REGS_SVH
`define WKT_REGS_SVH

// register byte offsets
`define WKT_OFF_CONFIG   8'h00
`define WKT_OFF_PERIOD   8'h04
`define WKT_OFF_DUTY     8'h08
`define WKT_OFF_IRQEN    8'h0C
`define WKT_OFF_THRESH   8'h10
`define WKT_OFF_STATUS   8'h14
`define WKT_OFF_ADCCMD   8'h18
`define WKT_OFF_ADCRES   8'h1C
`define WKT_OFF_STATE    8'h20
`define WKT_OFF_CMD      8'h24

// config field positions
`define WKT_CFG_EN       0
`define WKT_CFG_CALEN    1
`define WKT_CFG_CALPER   2
`define WKT_CFG_LOWBAT   5
`define WKT_CFG_DUTYRX   6
`define WKT_CFG_DUTYTX   7
`define WKT_CFG_CLKSEL   8
// period field positions
`define WKT_PER_MANT     0
`define WKT_PER_EXPO     16
// status / irq enable bit positions
`define WKT_ST_TIMER     0
`define WKT_ST_LOWBAT    1
`define WKT_ST_SENT      2
`define WKT_ST_CAL       3
`define WKT_IRQEN_GPIO   8
// command register bit
`define WKT_CMD_PWRUP    0

// reset values
`define WKT_RST_CONFIG   9'h000
`define WKT_RST_MANT     16'h0001
`define WKT_RST_EXPO     5'h00
`define WKT_RST_DUTY     8'h01
`define WKT_RST_IRQEN    4'h0
`define WKT_RST_THRESH   5'h00
`define WKT_RST_TRIM     8'h80

// timing
`define WKT_RC_HZ        32768
`define WKT_XO_HZ        30000000
`define WKT_CAL_TARGET   (`WKT_XO_HZ / `WKT_RC_HZ)
`define WKT_CAL_TOL      2
`define WKT_UNIT_TICKS   4
`define WKT_EXPO_MAX     5'd20

// bus responses
`define WKT_RESP_OKAY    2'b00
`define WKT_RESP_SLVERR  2'b10

`endif

/* core/wkt_pkg.sv */
package wkt_pkg;

  typedef enum logic [1:0] {
    WKT_IDLE,
    WKT_RX_WIN,
    WKT_RX_EXT,
    WKT_TX
  } wkt_duty_t;

  typedef enum logic [1:0] {
    WKT_CAL_OFF,
    WKT_CAL_ARM,
    WKT_CAL_CNT
  } wkt_cal_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } wkt_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wkt_axi_rsp_t;

  // pin-level inputs from the radio and analog front end
  typedef struct packed {
    logic        clk32_rc;
    logic        clk32_xtal;
    logic        xo_ref;
    logic        preamble_ok;
    logic        sync_ok;
    logic        pkt_done;
    logic        rx_err;
    logic        tx_done;
    logic        batt_below;
    logic        adc_done;
    logic [10:0] adc_data;
  } wkt_radio_in_t;

  typedef struct packed {
    wkt_axi_rsp_t axi;
    logic [2:0]  rc_s, xt_s, xo_s, txd_s, pkt_s, adc_s;
    logic [1:0]  pre_s, syn_s, err_s, bat_s;
    logic [8:0]  cfg;
    logic [15:0] mant;
    logic [4:0]  expo;
    logic [7:0]  duty;
    logic [3:0]  irq_en;
    logic        gpio_mode;
    logic [4:0]  thresh;
    logic [3:0]  status;
    logic        aw_ok, w_ok;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [22:0] presc;
    logic [15:0] units;
    logic [7:0]  exp_cnt;
    wkt_duty_t   st;
    logic [7:0]  dur;
    logic        ext;
    logic        rx_on;
    logic        tx_start;
    logic        cal_pend;
    wkt_cal_t    cal;
    logic [15:0] xo_cnt;
    logic [7:0]  trim;
    logic        xo_en;
    logic        adc_start;
    logic [2:0]  adc_sel;
    logic        adc_busy;
    logic [10:0] adc_res;
    logic        adc_val;
    logic        irq_n;
    logic        lowbat_pin;
  } wkt_state_t;

endpackage

/* core/wkt_top.sv */
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "wkt_regs.svh"

module wkt_top
  import wkt_pkg::*;
(
  input  wire logic          aclk,          // 100 MHz bus clock
  input  wire logic          aresetn,       // sync reset, active low
  input  wire wkt_axi_req_t  axi_req,       // AXI4-Lite master side
  output      wkt_axi_rsp_t  axi_rsp,       // AXI4-Lite slave side
  input  wire wkt_radio_in_t radio_in,      // async pins
  output      logic          irq_request_n, // interrupt line
  output      logic          lowbat_gpio,   // direct low battery pin
  output      logic          rx_on,         // radio receive enable
  output      logic          tx_start,      // one-cycle send request
  output      logic          xo_enable,     // main crystal enable
  output      logic [7:0]    rc_trim,       // RC oscillator trim
  output      logic          adc_start,     // converter start pulse
  output      logic [2:0]    adc_sel,       // pin, battery, temp
  output      logic [4:0]    batt_thresh    // comparator DAC code
);

  wkt_state_t q, d;
  logic       unit_w;
  logic       exp_w;

  always_comb begin
    logic        tick, rc_tick, xo_tick, txd, pkt, adc_edge;
    logic        dur_end, wr, rd_hit;
    logic [31:0] m, nw, rv;
    logic [4:0]  r;
    logic [22:0] unit_len;
    logic [3:0]  set;
    d        = q;
    set      = 4'h0;
    rv       = 32'h0000_0000;
    rd_hit   = 1'b1;
    d.tx_start  = 1'b0;
    d.adc_start = 1'b0;

    // synchronisers: stage 0 feeds stage 1, and stage 1 feeds stage 2 on the edge-detected inputs
    d.rc_s  = {q.rc_s[1:0],  radio_in.clk32_rc};
    d.xt_s  = {q.xt_s[1:0],  radio_in.clk32_xtal};
    d.xo_s  = {q.xo_s[1:0],  radio_in.xo_ref};
    d.txd_s = {q.txd_s[1:0], radio_in.tx_done};
    d.pkt_s = {q.pkt_s[1:0], radio_in.pkt_done};
    d.adc_s = {q.adc_s[1:0], radio_in.adc_done};
    d.pre_s = {q.pre_s[0],   radio_in.preamble_ok};
    d.syn_s = {q.syn_s[0],   radio_in.sync_ok};
    d.err_s = {q.err_s[0],   radio_in.rx_err};
    d.bat_s = {q.bat_s[0],   radio_in.batt_below};

    rc_tick  = q.rc_s[1] & ~q.rc_s[2];
    xo_tick  = q.xo_s[1] & ~q.xo_s[2];
    txd      = q.txd_s[1] & ~q.txd_s[2];
    pkt      = q.pkt_s[1] & ~q.pkt_s[2];
    adc_edge = q.adc_s[1] & ~q.adc_s[2];
    tick     = q.cfg[`WKT_CFG_CLKSEL] ? (q.xt_s[1] & ~q.xt_s[2])
                                      : rc_tick;

    // one period unit is 4 * 2^exponent ticks of 32768 Hz, with the exponent held at 20 above that
    r        = (q.expo > `WKT_EXPO_MAX) ? `WKT_EXPO_MAX : q.expo;
    unit_len = 23'(`WKT_UNIT_TICKS) << r;
    unit_w   = 1'b0;
    exp_w    = 1'b0;
    if (!q.cfg[`WKT_CFG_EN] || q.mant == 16'h0000) begin
      d.presc = 23'h00_0000;
      d.units = 16'h0000;
    end else if (tick) begin
      // >= so that a period rewritten mid-count cannot run past its end
      if (q.presc >= unit_len - 23'd1) begin
        d.presc = 23'h00_0000;
        unit_w  = 1'b1;
        if (q.units >= q.mant - 16'd1) begin
          d.units = 16'h0000;
          exp_w   = 1'b1;
        end else begin
          d.units = q.units + 16'd1;
        end
      end else begin
        d.presc = q.presc + 23'd1;
      end
    end

    if (exp_w) begin
      set[`WKT_ST_TIMER] = 1'b1;
      if (q.cfg[`WKT_CFG_LOWBAT] && q.bat_s[1]) begin
        set[`WKT_ST_LOWBAT] = 1'b1;
      end
      if (q.cfg[`WKT_CFG_CALEN]) begin
        if (q.exp_cnt >= (8'd1 << q.cfg[`WKT_CFG_CALPER +: 3]) - 8'd1) begin
          d.exp_cnt  = 8'h00;
          d.cal_pend = 1'b1;
        end else begin
          d.exp_cnt = q.exp_cnt + 8'd1;
        end
      end
    end

    // duty-cycled wake sequencer
    dur_end = unit_w && (q.dur >= q.duty - 8'd1);
    if (unit_w) begin
      d.dur = q.dur + 8'd1;
    end
    case (q.st)
      WKT_IDLE: begin
        d.rx_on = 1'b0;
        if (exp_w && q.cfg[`WKT_CFG_DUTYRX] && q.duty != 8'h00) begin
          d.st    = WKT_RX_WIN;
          d.rx_on = 1'b1;
          d.dur   = 8'h00;
          d.ext   = 1'b0;
        end else if (exp_w && q.cfg[`WKT_CFG_DUTYTX]) begin
          d.st       = WKT_TX;
          d.tx_start = 1'b1;
        end
      end
      WKT_RX_WIN: begin
        if (q.pre_s[1] || q.syn_s[1]) begin
          d.ext = 1'b1;
        end
        if (q.err_s[1]) begin
          d.ext = 1'b0;
        end
        if (pkt || !q.cfg[`WKT_CFG_EN]) begin
          d.st    = WKT_IDLE;
          d.rx_on = 1'b0;
        end else if (dur_end) begin
          d.dur = 8'h00;
          if (d.ext) begin
            d.st = WKT_RX_EXT;
          end else begin
            d.st    = WKT_IDLE;
            d.rx_on = 1'b0;
          end
        end
      end
      WKT_RX_EXT: begin
        if (pkt || dur_end || !q.cfg[`WKT_CFG_EN]) begin
          d.st    = WKT_IDLE;
          d.rx_on = 1'b0;
        end
      end
      WKT_TX: begin
        if (txd) begin
          d.st              = WKT_IDLE;
          set[`WKT_ST_SENT] = 1'b1;
        end
      end
      default: begin
        d.st    = WKT_IDLE;
        d.rx_on = 1'b0;
      end
    endcase

    // RC calibration against the crystal over one RC period
    case (q.cal)
      WKT_CAL_OFF: begin
        d.xo_en = 1'b0;
        if (q.cal_pend) begin
          d.cal_pend = 1'b0;
          d.cal      = WKT_CAL_ARM;
          d.xo_en    = 1'b1;
        end
      end
      WKT_CAL_ARM: begin
        // first RC edge also gives the crystal time to start
        if (rc_tick) begin
          d.cal    = WKT_CAL_CNT;
          d.xo_cnt = 16'h0000;
        end
      end
      WKT_CAL_CNT: begin
        if (rc_tick) begin
          // more crystal edges than nominal: RC too slow
          if (q.xo_cnt > 16'(`WKT_CAL_TARGET + `WKT_CAL_TOL)) begin
            d.trim = (q.trim == 8'hFF) ? q.trim : q.trim + 8'd1;
          end else if (q.xo_cnt < 16'(`WKT_CAL_TARGET - `WKT_CAL_TOL)) begin
            d.trim = (q.trim == 8'h00) ? q.trim : q.trim - 8'd1;
          end
          d.cal            = WKT_CAL_OFF;
          d.xo_en          = 1'b0;
          set[`WKT_ST_CAL] = 1'b1;
        end else if (xo_tick) begin
          d.xo_cnt = q.xo_cnt + 16'd1;
        end
      end
      default: begin
        d.cal   = WKT_CAL_OFF;
        d.xo_en = 1'b0;
      end
    endcase

    // converter: data is stable once the done pin rises
    if (adc_edge && q.adc_busy) begin
      d.adc_res  = radio_in.adc_data;
      d.adc_val  = 1'b1;
      d.adc_busy = 1'b0;
    end

    // AXI4-Lite write path, address and data in either order
    if (q.axi.awready && axi_req.awvalid) begin
      d.aw_ok   = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (q.axi.wready && axi_req.wvalid) begin
      d.w_ok   = 1'b1;
      d.w_data = axi_req.wdata;
      d.w_strb = axi_req.wstrb;
    end
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{q.w_strb[i]}};
    end
    wr = q.aw_ok && q.w_ok && !q.axi.bvalid;
    nw = q.w_data & m;
    d.status = q.status;
    if (wr) begin
      d.aw_ok      = 1'b0;
      d.w_ok       = 1'b0;
      d.axi.bvalid = 1'b1;
      d.axi.bresp  = `WKT_RESP_OKAY;
      case ({q.aw_addr[7:2], 2'b00})
        `WKT_OFF_CONFIG: d.cfg = (q.cfg & ~m[8:0]) | nw[8:0];
        `WKT_OFF_PERIOD: begin
          d.mant = (q.mant & ~m[15:0]) | nw[15:0];
          d.expo = (q.expo & ~m[20:16]) | nw[20:16];
        end
        `WKT_OFF_DUTY:   d.duty = (q.duty & ~m[7:0]) | nw[7:0];
        `WKT_OFF_IRQEN: begin
          d.irq_en    = (q.irq_en & ~m[3:0]) | nw[3:0];
          if (m[`WKT_IRQEN_GPIO]) begin
            d.gpio_mode = q.w_data[`WKT_IRQEN_GPIO];
          end
        end
        `WKT_OFF_THRESH: d.thresh = (q.thresh & ~m[4:0]) | nw[4:0];
        `WKT_OFF_STATUS: d.status = q.status & ~nw[3:0];
        `WKT_OFF_ADCCMD: begin
          if (m[0] && nw[2:0] != 3'b000) begin
            d.adc_sel   = nw[2:0];
            d.adc_start = 1'b1;
            d.adc_busy  = 1'b1;
            d.adc_val   = 1'b0;
          end
        end
        `WKT_OFF_CMD: begin
          if (nw[`WKT_CMD_PWRUP]) begin
            d.cal_pend = 1'b1;
          end
        end
        default: d.axi.bresp = `WKT_RESP_SLVERR;
      endcase
    end
    d.status = d.status | set; // set wins over a same-cycle clear
    if (q.axi.bvalid && axi_req.bready) begin
      d.axi.bvalid = 1'b0;
    end
    d.axi.awready = !d.aw_ok && !d.axi.bvalid;
    d.axi.wready  = !d.w_ok && !d.axi.bvalid;

    // AXI4-Lite read path
    case ({axi_req.araddr[7:2], 2'b00})
      `WKT_OFF_CONFIG: rv[8:0] = q.cfg;
      `WKT_OFF_PERIOD: rv = {11'h000, q.expo, q.mant};
      `WKT_OFF_DUTY:   rv[7:0] = q.duty;
      `WKT_OFF_IRQEN:  rv[8:0] = {q.gpio_mode, 4'h0, q.irq_en};
      `WKT_OFF_THRESH: rv[4:0] = q.thresh;
      `WKT_OFF_STATUS: rv[3:0] = q.status;
      `WKT_OFF_ADCCMD: rv[3:0] = {q.adc_busy, q.adc_sel};
      `WKT_OFF_ADCRES: rv = {q.adc_val, 20'h0_0000, q.adc_res};
      `WKT_OFF_STATE:  rv[13:0] = {q.trim, q.cal, q.st, q.ext, q.rx_on};
      `WKT_OFF_CMD:    rv = 32'h0000_0000;
      default:         rd_hit = 1'b0;
    endcase
    if (q.axi.arready && axi_req.arvalid) begin
      d.axi.arready = 1'b0;
      d.axi.rvalid  = 1'b1;
      d.axi.rdata   = rv;
      d.axi.rresp   = rd_hit ? `WKT_RESP_OKAY : `WKT_RESP_SLVERR;
    end else if (q.axi.rvalid && axi_req.rready) begin
      d.axi.rvalid  = 1'b0;
      d.axi.arready = 1'b1;
    end

    // low battery goes to the pin instead of the irq when routed
    // next enables, so the line follows a new mask without a stale cycle
    d.lowbat_pin = d.gpio_mode && d.status[`WKT_ST_LOWBAT];
    d.irq_n = ~|(d.status & d.irq_en &
                 {2'b11, ~d.gpio_mode, 1'b1});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q             <= '0;
      q.cfg         <= `WKT_RST_CONFIG;
      q.mant        <= `WKT_RST_MANT;
      q.expo        <= `WKT_RST_EXPO;
      q.duty        <= `WKT_RST_DUTY;
      q.irq_en      <= `WKT_RST_IRQEN;
      q.thresh      <= `WKT_RST_THRESH;
      q.trim        <= `WKT_RST_TRIM;
      q.st          <= WKT_IDLE;
      q.cal         <= WKT_CAL_OFF;
      q.cal_pend    <= 1'b1; // reset covers power-up and shutdown exit
      q.irq_n       <= 1'b1;
      q.axi.awready <= 1'b1;
      q.axi.wready  <= 1'b1;
      q.axi.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign axi_rsp       = q.axi;
  assign irq_request_n = q.irq_n;
  assign lowbat_gpio   = q.lowbat_pin;
  assign rx_on         = q.rx_on;
  assign tx_start      = q.tx_start;
  assign xo_enable     = q.xo_en;
  assign rc_trim       = q.trim;
  assign adc_start     = q.adc_start;
  assign adc_sel       = q.adc_sel;
  assign batt_thresh   = q.thresh;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_expiry_sets_flag: assert property (
    exp_w |=> q.status[`WKT_ST_TIMER] ##1 1) else
    $error("expiry did not set timer flag");
  a_period_restart: assert property (
    exp_w |=> q.units == 16'h0000 && q.presc == 23'h00_0000) else
    $error("period count not restarted");
  a_irq_pending: assert property (
    q.status[`WKT_ST_TIMER] && q.irq_en[`WKT_ST_TIMER] |-> !irq_request_n)
    else $error("pending timer event not on irq");
  a_irq_quiet: assert property (
    (q.status & q.irq_en) == 4'h0 |-> irq_request_n) else
    $error("irq low without enabled event");
  a_rx_wake: assert property (
    exp_w && q.st == WKT_IDLE && q.cfg[`WKT_CFG_DUTYRX] && q.duty != 8'h00
    |=> q.st == WKT_RX_WIN && rx_on) else
    $error("receive wake not started");
  a_rx_two_max: assert property (
    q.st == WKT_RX_EXT && unit_w && q.dur >= q.duty - 8'd1
    |=> q.st == WKT_IDLE ##1 !rx_on) else
    $error("receive window exceeded two durations");
  a_tx_return: assert property (
    q.st == WKT_TX && q.txd_s[1] && !q.txd_s[2]
    |=> q.st == WKT_IDLE && q.status[`WKT_ST_SENT]) else
    $error("send did not end in idle with flag");
  a_lowbat_cause: assert property (
    $rose(q.status[`WKT_ST_LOWBAT]) |-> $past(exp_w) &&
    $past(q.cfg[`WKT_CFG_LOWBAT]) && $past(q.cfg[`WKT_CFG_EN])) else
    $error("low battery flag without enabled expiry");
  a_cal_xo_on: assert property (
    q.cal == WKT_CAL_CNT |-> xo_enable) else
    $error("crystal off during calibration");
  a_adc_start: assert property (
    adc_start |-> adc_sel != 3'b000 ##1 !adc_start) else
    $error("converter start malformed");

  c_rx_extended: cover property (q.st == WKT_RX_EXT ##[1:1000] q.st == WKT_IDLE);
  c_tx_sent: cover property (q.st == WKT_TX ##1 q.status[`WKT_ST_SENT]);
  c_cal_done: cover property ($rose(q.status[`WKT_ST_CAL]));

endmodule

/* bench/wkt_radio_model.sv */
`timescale 1ns/100ps
module wkt_radio_model
  import wkt_pkg::*;
(
  input  wire logic          aclk,      // bus clock
  input  wire logic          xo_enable, // crystal run request
  input  wire logic          tx_start,  // send request pulse
  input  wire logic          adc_start, // conversion start pulse
  input  wire logic          preamble,  // bench: preamble on air
  input  wire logic          low_batt,  // bench: supply low
  output      wkt_radio_in_t radio_in,  // front-end pins
  output      logic [10:0]   adc_last   // last converted value
);
  int seed;
  initial begin
    seed = 86;
    radio_in = '0;
    adc_last = 11'h000;
  end
  // 32 kHz sources sped up: the timer only counts their edges
  always #200 radio_in.clk32_rc = ~radio_in.clk32_rc;
  always #240 radio_in.clk32_xtal = ~radio_in.clk32_xtal;
  // reference stands still unless the crystal is started
  always #16.7 radio_in.xo_ref = xo_enable & ~radio_in.xo_ref;
  always @* begin
    radio_in.preamble_ok = preamble;
    radio_in.batt_below = low_batt;
  end
  always @(negedge aclk) begin
    if (tx_start) begin
      repeat (20) @(negedge aclk);
      radio_in.tx_done = 1'b1;
      repeat (4) @(negedge aclk);
      radio_in.tx_done = 1'b0;
    end
  end
  always @(negedge aclk) begin
    if (adc_start) begin
      repeat (30) @(negedge aclk);
      adc_last = 11'($random(seed));
      radio_in.adc_data = adc_last;
      radio_in.adc_done = 1'b1;
      repeat (6) @(negedge aclk);
      radio_in.adc_done = 1'b0;
      // hold time over: the bus no longer shows the result
      radio_in.adc_data = ~adc_last;
    end
  end
endmodule

/* bench/tb.sv */
`timescale 1ns/100ps
`include "wkt_regs.svh"
module tb
  import wkt_pkg::*;
;
  typedef struct packed {
    logic        rd;
    logic [1:0]  resp;
    logic [31:0] data;
    logic [31:0] mask;
  } wkt_note_t;
  logic          aclk, aresetn, irq_request_n, lowbat_gpio, rx_on;
  logic          tx_start, xo_enable, adc_start, preamble, low_batt;
  logic          use_xt;
  wkt_axi_req_t  axi_req;
  wkt_axi_rsp_t  axi_rsp;
  wkt_radio_in_t radio_in;
  logic [7:0]    rc_trim;
  logic [2:0]    adc_sel, sel_seen;
  logic [4:0]    batt_thresh;
  logic [10:0]   adc_last;
  logic [15:0]   mant;
  wkt_note_t     note_q[$];
  int            err_count, cmp_count, seed, ticks, xo_rises, base;

  wkt_top dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .radio_in(radio_in), .irq_request_n(irq_request_n),
    .lowbat_gpio(lowbat_gpio), .rx_on(rx_on), .tx_start(tx_start),
    .xo_enable(xo_enable), .rc_trim(rc_trim), .adc_start(adc_start),
    .adc_sel(adc_sel), .batt_thresh(batt_thresh)
  );
  wkt_radio_model model (
    .aclk(aclk), .xo_enable(xo_enable), .tx_start(tx_start),
    .adc_start(adc_start), .preamble(preamble), .low_batt(low_batt),
    .radio_in(radio_in), .adc_last(adc_last)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge radio_in.clk32_rc) if (!use_xt) ticks++;
  always @(posedge radio_in.clk32_xtal) if (use_xt) ticks++;
  always @(posedge xo_enable) xo_rises++;
  always @(negedge aclk) if (adc_start === 1'b1) sel_seen <= adc_sel;

  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_val(string what, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  // sync delay of the tick input allows one tick either way
  task automatic cmp_ticks(string what, int e);
    cmp_val(what, e, (ticks >= e - 1 && ticks <= e + 1) ? e : ticks);
  endtask

  // ready levels are flops: the value at negedge is what the edge sees
  task automatic axi_write(logic [7:0] a, logic [31:0] d,
                           logic [1:0] r = `WKT_RESP_OKAY);
    bit aw, w;
    note_q.push_back('{1'b0, r, 32'h0000_0000, 32'h0000_0000});
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw = axi_req.awvalid && axi_rsp.awready;
      w = axi_req.wvalid && axi_rsp.wready;
      if (axi_rsp.bvalid) break;
      @(posedge aclk);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
    end
    @(posedge aclk);
    axi_req.bready <= 1'b0;
  endtask

  task automatic axi_read(logic [7:0] a, logic [31:0] e,
                          logic [31:0] m = 32'hFFFF_FFFF,
                          logic [1:0] r = `WKT_RESP_OKAY);
    bit t;
    note_q.push_back('{1'b1, r, e & m, m});
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    forever begin
      @(negedge aclk);
      if (axi_rsp.rvalid) break;
      t = axi_rsp.arready;
      @(posedge aclk);
      if (t) axi_req.arvalid <= 1'b0;
    end
    @(posedge aclk);
    axi_req.rready <= 1'b0;
  endtask

  always @(negedge aclk) begin
    wkt_note_t nt;
    if ((axi_rsp.bvalid && axi_req.bready) ||
        (axi_rsp.rvalid && axi_req.rready)) begin
      nt = note_q.pop_front();
      if (nt.rd) begin
        cmp_val("rdata", nt.data, axi_rsp.rdata & nt.mask);
        cmp_val("rresp", nt.resp, axi_rsp.rresp);
      end else
        cmp_val("bresp", nt.resp, axi_rsp.bresp);
    end
  end

  initial begin
    #900000;
    err_count++;
    give_verdict();
  end

  initial begin
    seed = 86;
    axi_req = '0;
    aresetn = 1'b0;
    preamble = 1'b0;
    low_batt = 1'b0;
    use_xt = 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    cmp_val("irq_n", 1, irq_request_n);
    cmp_val("trim", 32'h0000_0080, rc_trim);
    @(posedge aclk);
    aresetn <= 1'b1;
    wait (xo_enable === 1'b1);
    wait (xo_enable === 1'b0);
    repeat (3) @(negedge aclk);
    cmp_val("trim", 32'h0000_007F, rc_trim);
    axi_read(`WKT_OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
    axi_read(`WKT_OFF_PERIOD, 32'h0000_0001);
    axi_read(`WKT_OFF_DUTY, 32'h0000_0001);
    axi_read(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, `WKT_RESP_SLVERR);
    axi_write(8'h40, 32'h0000_FFFF, `WKT_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      automatic logic [4:0] v = (i < 2) ? 5'(i * 31) : 5'($random(seed));
      axi_write(`WKT_OFF_THRESH, 32'(v));
      @(negedge aclk);
      cmp_val("thresh", 32'(v), batt_thresh);
    end
    for (int i = 0; i < 2; i++) begin
      use_xt = i[0];
      mant = 16'(1 + ($random(seed) & 1));
      axi_write(`WKT_OFF_IRQEN, 32'h0000_0000);
      axi_write(`WKT_OFF_PERIOD, (i << 16) | mant);
      axi_write(`WKT_OFF_CONFIG, (i << 8) | 1);
      repeat ((mant * 260) << i) @(negedge aclk);
      cmp_val("masked irq_n", 1, irq_request_n);
      axi_read(`WKT_OFF_STATUS, 1, 1);
      axi_write(`WKT_OFF_IRQEN, 1);
      repeat (2) @(negedge aclk);
      cmp_val("irq_n", 0, irq_request_n);
      axi_write(`WKT_OFF_STATUS, 1);
      wait (irq_request_n === 1'b0);
      ticks = 0;
      axi_write(`WKT_OFF_STATUS, 1);
      wait (irq_request_n === 1'b0);
      cmp_ticks("period", (mant * 4) << i);
    end
    cmp_val("xo starts", 1, xo_rises);
    use_xt = 1'b0;
    axi_write(`WKT_OFF_PERIOD, 32'h0000_0002);
    axi_write(`WKT_OFF_CONFIG, 32'h0000_0007);
    base = xo_rises;
    repeat (4) begin
      axi_write(`WKT_OFF_STATUS, 32'h0000_000F);
      wait (irq_request_n === 1'b0);
    end
    repeat (40) @(negedge aclk);
    cmp_val("recal count", 2, xo_rises - base);
    axi_write(`WKT_OFF_CONFIG, 32'h0000_0020);
    axi_write(`WKT_OFF_STATUS, 32'h0000_000F);
    low_batt <= 1'b1;
    repeat (400) @(negedge aclk);
    axi_read(`WKT_OFF_STATUS, 32'h0000_0000, 32'h0000_0002);
    axi_write(`WKT_OFF_IRQEN, 32'h0000_0002);
    axi_write(`WKT_OFF_CONFIG, 32'h0000_0021);
    wait (irq_request_n === 1'b0);
    axi_read(`WKT_OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    axi_write(`WKT_OFF_IRQEN, 32'h0000_0102);
    repeat (2) @(negedge aclk);
    cmp_val("gpio", 1, lowbat_gpio);
    cmp_val("irq_n", 1, irq_request_n);
    low_batt <= 1'b0;
    axi_write(`WKT_OFF_IRQEN, 32'h0000_0000);
    mant = 16'(1 + ($random(seed) & 1));
    axi_write(`WKT_OFF_DUTY, 32'(mant));
    axi_write(`WKT_OFF_PERIOD, 32'h0000_0008);
    axi_write(`WKT_OFF_CONFIG, 32'h0000_0041);
    for (int i = 0; i < 2; i++) begin
      preamble <= i[0];
      wait (rx_on === 1'b1);
      ticks = 0;
      wait (rx_on === 1'b0);
      cmp_ticks("rx window", (mant * 4) << i);
    end
    preamble <= 1'b0;
    axi_write(`WKT_OFF_IRQEN, 32'h0000_0004);
    axi_write(`WKT_OFF_STATUS, 32'h0000_000F);
    axi_write(`WKT_OFF_CONFIG, 32'h0000_0081);
    @(negedge aclk iff tx_start === 1'b1);
    cmp_val("rx_on", 0, rx_on);
    cmp_val("irq_n", 1, irq_request_n);
    @(negedge aclk);
    cmp_val("tx_start", 0, tx_start);
    wait (irq_request_n === 1'b0);
    axi_read(`WKT_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
    for (int k = 0; k < 3; k++) begin
      axi_write(`WKT_OFF_ADCCMD, 32'h0000_0001 << k);
      wait (radio_in.adc_done === 1'b1);
      repeat (8) @(negedge aclk);
      cmp_val("adc sel", 32'h0000_0001 << k, sel_seen);
      axi_read(`WKT_OFF_ADCRES, {1'b1, 20'h0_0000, adc_last},
               32'h8000_07FF);
    end
    give_verdict();
  end
endmodule
